// File: include/dac_serial_consts.vh
// constants for the dual 12-bit converter serial front end
// assumes inclusion by bare name from every design file that needs them
`ifndef DAC_SERIAL_CONSTS_VH
`define DAC_SERIAL_CONSTS_VH

// ------------------------------------------------------------
// frame geometry
// ------------------------------------------------------------
`define FRAME_BITS 24
`define FRAME_LAST 5'd24
`define BIT_CNT_W 5
`define BIT_CNT_ZERO 5'd0
`define BIT_CNT_ONE 5'd1

// ------------------------------------------------------------
// field positions inside one 24-bit frame
// ------------------------------------------------------------
`define CMD_HI 21
`define CMD_LO 19
`define ADDR_HI 18
`define ADDR_LO 16
`define DATA_HI 15
`define DATA_LO 4
`define REF_SEL_BIT 0

// ------------------------------------------------------------
// command codes
// ------------------------------------------------------------
`define CMD_WR_INPUT 3'h0
`define CMD_UPD_DAC 3'h1
`define CMD_WR_UPD_ALL 3'h2
`define CMD_WR_UPD_ONE 3'h3
`define CMD_REF_SETUP 3'h7

// ------------------------------------------------------------
// channel address codes
// ------------------------------------------------------------
`define ADDR_CH_A 3'h0
`define ADDR_CH_B 3'h1
`define ADDR_CH_ALL 3'h7

// ------------------------------------------------------------
// reset values and buffering
// ------------------------------------------------------------
`define CODE_W 12
`define ZERO_CODE 12'h000
`define REF_OUT_RESET 1'b0
`define FIFO_DEPTH 8
`define FIFO_AW 3

`endif

// File: hdl/dual_dac_serial_load_and_clear.v
// serial write front end and register update logic of a dual 12-bit
// converter, plus the frame fifo that sits between capture and decode.
// assumes: sys_clk at 40 MHz; every pin input is asynchronous to it and
// the serial clock is slow enough (bench: 200 ns) to be oversampled.
`timescale 1ns/10ps
`include "dac_serial_consts.vh"
// ------------------------------------------------------------
// frame fifo
// ------------------------------------------------------------
module frame_fifo #(
  parameter WIDTH = 24,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire clk, // system clock
  input wire rst_n, // asynchronous reset, active low
  input wire flush, // drop every stored word
  input wire in_valid, // word offered
  output reg in_ready, // room for a word
  input wire [WIDTH-1:0] in_data, // word to store
  output wire out_valid, // word available
  input wire out_ready, // consumer takes the word
  output wire [WIDTH-1:0] out_data // oldest word
);
  reg [WIDTH-1:0] mem [0:DEPTH-1]; // storage
  reg [AW-1:0] wr_ptr_r; // write index
  reg [AW-1:0] rd_ptr_r; // read index
  reg [AW:0] count_r; // words held
  wire push; // a word enters
  wire pop; // a word leaves
  assign push = in_valid && in_ready && !flush;
  assign pop = out_valid && out_ready && !flush;
  assign out_valid = (count_r != {(AW+1){1'b0}});
  assign out_data = mem[rd_ptr_r];
  // storage has no reset; only words below count_r are ever read
  always @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_r] <= in_data;
    end
  end
  // pointers, fill level and registered ready
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_r <= {AW{1'b0}};
      rd_ptr_r <= {AW{1'b0}};
      count_r <= {(AW+1){1'b0}};
      in_ready <= 1'b1;
    end else if (flush) begin
      wr_ptr_r <= {AW{1'b0}};
      rd_ptr_r <= {AW{1'b0}};
      count_r <= {(AW+1){1'b0}};
      in_ready <= 1'b1;
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + {{(AW-1){1'b0}}, 1'b1};
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + {{(AW-1){1'b0}}, 1'b1};
      end
      case ({push, pop})
        2'b10: begin
          count_r <= count_r + {{AW{1'b0}}, 1'b1};
          // ready is registered from the next fill level, so it drops as the last slot fills
          in_ready <= (count_r + {{AW{1'b0}}, 1'b1}) < DEPTH;
        end
        2'b01: begin
          count_r <= count_r - {{AW{1'b0}}, 1'b1};
          in_ready <= 1'b1;
        end
        default: begin
          count_r <= count_r;
          in_ready <= in_ready;
        end
      endcase
    end
  end
endmodule
// ------------------------------------------------------------
// top: serial capture, clear logic and channel registers
// ------------------------------------------------------------
module dual_dac_serial_load_and_clear (
  input wire sys_clk, // 40 MHz system clock
  input wire rst_n, // asynchronous reset, active low
  input wire sync_n, // frame select pin, active low
  input wire sclk, // serial shift clock pin
  input wire din, // serial data pin
  input wire load_strobe_n, // load strobe pin, active low
  input wire async_clear_n, // clear pin, active low
  output reg [11:0] channel_a_output, // converter register a
  output reg [11:0] channel_b_output, // converter register b
  output reg ref_out_en, // reference pin drives out when high
  output reg clear_mode, // zero-scale clear mode active
  output reg frame_ready // fifo can accept another frame
);
  // decode helpers: does an address select a given channel
  function sel_a;
    input [2:0] addr;
    begin
      sel_a = (addr == `ADDR_CH_A) || (addr == `ADDR_CH_ALL);
    end
  endfunction
  function sel_b;
    input [2:0] addr;
    begin
      sel_b = (addr == `ADDR_CH_B) || (addr == `ADDR_CH_ALL);
    end
  endfunction
  // ------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------
  reg [4:0] meta_r; // first stage, read only by second stage
  reg [4:0] sync_r; // second stage, safe to use
  reg sclk_d_r; // delayed serial clock for edge detect
  reg sync_d_r; // delayed frame select for edge detect
  reg clr_d_r; // delayed clear for edge detect
  wire sclk_s; // synchronised serial clock
  wire sync_s; // synchronised frame select
  wire din_s; // synchronised data
  wire load_strobe_n_s; // synchronised load strobe
  wire clr_s; // synchronised clear
  assign sclk_s = sync_r[0];
  assign sync_s = sync_r[1];
  assign din_s = sync_r[2];
  assign load_strobe_n_s = sync_r[3];
  assign clr_s = sync_r[4];
  // two flops on every pin; data shares the clock's latency so the
  // bit seen at a detected edge is the bit present at the pin edge
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= 5'h1b;
      sync_r <= 5'h1b;
      sclk_d_r <= 1'b1;
      sync_d_r <= 1'b1;
      clr_d_r <= 1'b1;
    end else begin
      meta_r <= {async_clear_n, load_strobe_n, din, sync_n, sclk};
      sync_r <= meta_r;
      sclk_d_r <= sclk_s;
      sync_d_r <= sync_s;
      clr_d_r <= clr_s;
    end
  end
  wire sclk_fall; // serial clock fell
  wire sync_fall; // frame select fell
  wire sync_rise; // frame select rose
  wire clr_fall; // clear fell
  assign sclk_fall = sclk_d_r && !sclk_s;
  assign sync_fall = sync_d_r && !sync_s;
  assign sync_rise = !sync_d_r && sync_s;
  assign clr_fall = clr_d_r && !clr_s;
  // ------------------------------------------------------------
  // frame capture
  // ------------------------------------------------------------
  reg [23:0] shift_r;
  reg [4:0] bit_cnt_r; // falling edges seen this frame
  reg abort_r; // frame killed by clear, wait for select high
  reg push_r; // one-cycle frame offer to the fifo
  reg [23:0] frame_r; // completed frame held for the fifo
  wire fifo_in_ready; // fifo has room
  wire shift_en; // capture enabled this cycle
  // a frame that finds the fifo full is lost, so frame_ready tells the
  // master to pause; at 200 ns bits the decoder only falls behind while clear is held low
  assign shift_en = !sync_s && !abort_r && (bit_cnt_r != `FRAME_LAST);
  // shift register, bit counter and abort flag
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_r <= 24'h000000;
      bit_cnt_r <= `BIT_CNT_ZERO;
      abort_r <= 1'b0;
      push_r <= 1'b0;
      frame_r <= 24'h000000;
    end else begin
      push_r <= 1'b0;
      if (clr_fall) begin
        // clear wins over any edge in the same cycle
        bit_cnt_r <= `BIT_CNT_ZERO;
        abort_r <= !sync_s;
      end else if (sync_fall) begin
        bit_cnt_r <= `BIT_CNT_ZERO;
        abort_r <= 1'b0;
      end else if (sync_rise) begin
        // partial frame dropped, nothing was pushed
        bit_cnt_r <= `BIT_CNT_ZERO;
        abort_r <= 1'b0;
      end else if (shift_en && sclk_fall) begin
        shift_r <= {shift_r[22:0], din_s};
        bit_cnt_r <= bit_cnt_r + `BIT_CNT_ONE;
        if (bit_cnt_r == (`FRAME_LAST - `BIT_CNT_ONE)) begin
          frame_r <= {shift_r[22:0], din_s};
          push_r <= 1'b1;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // fifo between capture and decode
  // ------------------------------------------------------------
  wire fifo_out_valid; // a frame waits for decode
  wire [23:0] fifo_out_data; // oldest frame
  wire fifo_out_ready; // decode takes it
  wire fifo_flush; // drop queued frames on clear
  // decode stalls while clear is held low, so frames queue up
  assign fifo_out_ready = clr_s;
  assign fifo_flush = clr_fall;
  frame_fifo #(
    .WIDTH(`FRAME_BITS),
    .DEPTH(`FIFO_DEPTH),
    .AW(`FIFO_AW)
  ) u_fifo (
    .clk(sys_clk),
    .rst_n(rst_n),
    .flush(fifo_flush),
    .in_valid(push_r),
    .in_ready(fifo_in_ready),
    .in_data(frame_r),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );
  // ------------------------------------------------------------
  // frame decode
  // ------------------------------------------------------------
  wire take; // a frame is decoded this cycle
  wire [2:0] cmd; // command field
  wire [2:0] addr; // channel address field
  wire [11:0] code; // data code
  assign take = fifo_out_valid && fifo_out_ready;
  assign cmd = fifo_out_data[`CMD_HI:`CMD_LO];
  assign addr = fifo_out_data[`ADDR_HI:`ADDR_LO];
  assign code = fifo_out_data[`DATA_HI:`DATA_LO];
  reg wr_a; // write input register a
  reg wr_b; // write input register b
  reg up_a; // software update of converter a
  reg up_b; // software update of converter b
  reg ref_wr; // reference setup frame
  // command decoding; unlisted commands are accepted and ignored
  always @* begin
    wr_a = 1'b0;
    wr_b = 1'b0;
    up_a = 1'b0;
    up_b = 1'b0;
    ref_wr = 1'b0;
    if (take) begin
      case (cmd)
        `CMD_WR_INPUT: begin
          wr_a = sel_a(addr);
          wr_b = sel_b(addr);
        end
        `CMD_UPD_DAC: begin
          up_a = sel_a(addr);
          up_b = sel_b(addr);
        end
        `CMD_WR_UPD_ALL: begin
          wr_a = sel_a(addr);
          wr_b = sel_b(addr);
          up_a = 1'b1;
          up_b = 1'b1;
        end
        `CMD_WR_UPD_ONE: begin
          wr_a = sel_a(addr);
          wr_b = sel_b(addr);
          up_a = sel_a(addr);
          up_b = sel_b(addr);
        end
        `CMD_REF_SETUP: begin
          ref_wr = 1'b1;
        end
        default: begin
          ref_wr = 1'b0;
        end
      endcase
    end
  end
  // ------------------------------------------------------------
  // channel registers
  // ------------------------------------------------------------
  reg [11:0] in_a_r; // input register a
  reg [11:0] in_b_r; // input register b
  reg pend_a_r; // input a newer than converter a
  reg pend_b_r; // input b newer than converter b
  wire load_strobe_n_go; // hardware load request
  // a low level loads, so a strobe tied low updates on every write
  // limitation: a strobe pulse shorter than one clock may be missed
  assign load_strobe_n_go = !load_strobe_n_s && clr_s;
  // input registers, pending flags, converter registers
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      in_a_r <= `ZERO_CODE;
      in_b_r <= `ZERO_CODE;
      pend_a_r <= 1'b0;
      pend_b_r <= 1'b0;
      channel_a_output <= `ZERO_CODE;
      channel_b_output <= `ZERO_CODE;
    end else if (clr_fall) begin
      in_a_r <= `ZERO_CODE;
      in_b_r <= `ZERO_CODE;
      pend_a_r <= 1'b0;
      pend_b_r <= 1'b0;
      channel_a_output <= `ZERO_CODE;
      channel_b_output <= `ZERO_CODE;
    end else begin
      if (wr_a) begin
        in_a_r <= code;
      end
      if (wr_b) begin
        in_b_r <= code;
      end
      // software update writes through; the new code goes out at once
      if (up_a) begin
        channel_a_output <= wr_a ? code : in_a_r;
      end else if (load_strobe_n_go && pend_a_r) begin
        channel_a_output <= in_a_r;
      end
      if (up_b) begin
        channel_b_output <= wr_b ? code : in_b_r;
      end else if (load_strobe_n_go && pend_b_r) begin
        channel_b_output <= in_b_r;
      end
      // a write in the same cycle as a load keeps pending set
      pend_a_r <= (wr_a && !up_a) ||
        (pend_a_r && !up_a && !load_strobe_n_go);
      pend_b_r <= (wr_b && !up_b) ||
        (pend_b_r && !up_b && !load_strobe_n_go);
    end
  end

  // ------------------------------------------------------------
  // reference select, clear mode, fifo status
  // ------------------------------------------------------------
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ref_out_en <= `REF_OUT_RESET;
      clear_mode <= 1'b0;
      frame_ready <= 1'b1;
    end else begin
      if (ref_wr) begin
        ref_out_en <= fifo_out_data[`REF_SEL_BIT];
      end
      // clear set wins over a frame ending in the same cycle
      if (clr_fall) begin
        clear_mode <= 1'b1;
      end else if (push_r) begin
        clear_mode <= 1'b0;
      end
      frame_ready <= fifo_in_ready;
    end
  end
endmodule

// File: dv/dac_load_checker.sv
// port checks for the dual converter serial front end
// assumes one 40 MHz domain and a clear held low for many cycles
`timescale 1ns/10ps
module dac_load_checker (
  input wire sys_clk, // system clock
  input wire rst_n, // reset, active low
  input wire sync_n, // frame select
  input wire sclk, // serial clock
  input wire din, // serial data
  input wire load_strobe_n, // load strobe
  input wire async_clear_n, // clear pin
  input wire [11:0] channel_a_output, // converter a
  input wire [11:0] channel_b_output, // converter b
  input wire ref_out_en, // reference drive
  input wire clear_mode, // clear code mode
  input wire frame_ready // fifo room
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // ------------------------------------------------------------
  // clear sequences
  // ------------------------------------------------------------
  // fall plus five low cycles covers the pin synchroniser delay
  sequence clear_held_s;
    $fell(async_clear_n) ##1 !async_clear_n [*5];
  endsequence
  sequence clear_long_s;
    !async_clear_n [*8];
  endsequence
  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  rst_vals_a: assert property ($rose(rst_n) |->
    !ref_out_en && !clear_mode && frame_ready)
    else $error("reset values wrong");
  clear_zero_a: assert property (clear_held_s |-> clear_mode &&
    channel_a_output == 12'h000 && channel_b_output == 12'h000)
    else $error("clear did not zero outputs");
  clear_hold_a: assert property (clear_long_s |->
    $stable(channel_a_output) && $stable(channel_b_output))
    else $error("outputs moved while clear low");
  clear_cause_a: assert property ($rose(clear_mode) |->
    !$past(async_clear_n, 2))
    else $error("clear mode without clear");
  mode_exit_a: assert property ($fell(clear_mode) |->
    !$past(sync_n, 8))
    else $error("clear mode left without frame");
  ref_cause_a: assert property ($changed(ref_out_en) |->
    !$past(sync_n, 8))
    else $error("reference drive changed without frame");
  full_cause_a: assert property ($fell(frame_ready) |->
    !async_clear_n)
    else $error("fifo filled while decode ran");
  drain_only_a: assert property ($rose(frame_ready) |->
    async_clear_n || $past(async_clear_n, 8))
    else $error("fifo drained while clear low");
endmodule

bind dual_dac_serial_load_and_clear dac_load_checker i_chk (.sys_clk,
  .rst_n, .sync_n, .sclk, .din, .load_strobe_n, .async_clear_n,
  .channel_a_output, .channel_b_output, .ref_out_en, .clear_mode,
  .frame_ready);

// File: dv/serial_master.sv
// behavioural serial master that writes frames to the converter
// assumes the caller waits for each frame to end before the next
`timescale 1ns/10ps
module serial_master (
  output logic sync_n, // frame select, active low
  output logic sclk, // serial clock, stands high outside frames
  output logic din // serial data
);
  initial begin
    sync_n = 1'b1;
    sclk = 1'b1;
    din = 1'b0;
  end
  // ------------------------------------------------------------
  // frame writer: msb first, 200 ns serial period
  // ------------------------------------------------------------
  // nbits below 24 gives a cut-short frame
  task automatic send(input logic [23:0] word, input int nbits);
    sync_n = 1'b0;
    #100;
    for (int i = 0; i < nbits; i++) begin
      din = word[23-i];
      #100 sclk = 1'b0;
      #100 sclk = 1'b1;
    end
    #50 sync_n = 1'b1;
    din = ~din; // released line must not keep the last bit
    #100;
  endtask
endmodule

// File: dv/dual_dac_serial_load_and_clear_bench.sv
// self-checking bench for the dual converter serial front end
// assumes the serial master model and the checker bind compile first
`timescale 1ns/10ps
`include "dac_serial_consts.vh"
module dual_dac_serial_load_and_clear_bench;
  logic sys_clk; // 40 MHz clock
  logic rst_n; // reset, active low
  logic load_strobe_n; // load strobe, active low
  logic async_clear_n; // clear, active low
  wire sync_n, sclk, din; // serial link from the master model
  wire [11:0] chan_a, chan_b; // converter registers
  wire ref_out_en, clear_mode, frame_ready; // status outputs
  int failures = 0; // mismatches
  int check_count = 0; // comparisons

  dual_dac_serial_load_and_clear i_dut (.sys_clk(sys_clk), .rst_n(rst_n),
    .sync_n(sync_n), .sclk(sclk), .din(din),
    .load_strobe_n(load_strobe_n), .async_clear_n(async_clear_n),
    .channel_a_output(chan_a), .channel_b_output(chan_b),
    .ref_out_en(ref_out_en), .clear_mode(clear_mode),
    .frame_ready(frame_ready));
  serial_master i_master (.sync_n(sync_n), .sclk(sclk), .din(din));

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t ns: seen %h expected %h", $time,
        seen, exp);
    end
  endtask

  // inputs move 1 ns after the edge, never on it
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  function automatic logic [23:0] frame(input logic [2:0] cmd,
    input logic [2:0] addr, input logic [11:0] code);
    return {2'h0, cmd, addr, code, 4'h0};
  endfunction

  // whole frame, then room for decode to land
  task automatic put(input logic [2:0] cmd, input logic [2:0] addr,
    input logic [11:0] code);
    i_master.send(frame(cmd, addr, code), 24);
    tick(4);
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_update;
    put(`CMD_WR_UPD_ONE, `ADDR_CH_A, 12'ha5c);
    check(chan_a, 12'ha5c);
    check(chan_b, 12'h000);
    put(`CMD_WR_UPD_ONE, `ADDR_CH_B, 12'h3f1);
    check(chan_b, 12'h3f1);
  endtask

  // pending input must wait for the strobe, then both move together
  task automatic t_strobe;
    put(`CMD_WR_INPUT, `ADDR_CH_ALL, 12'h7e2);
    check({chan_a, chan_b}, 24'ha5c3f1);
    load_strobe_n = 1'b0;
    tick(4);
    load_strobe_n = 1'b1;
    tick(2);
    check({chan_a, chan_b}, 24'h7e27e2);
    put(`CMD_WR_INPUT, `ADDR_CH_A, 12'h111);
    put(`CMD_UPD_DAC, `ADDR_CH_A, 12'h000);
    check(chan_a, 12'h111);
    put(`CMD_WR_UPD_ALL, `ADDR_CH_B, 12'h222);
    check({chan_a, chan_b}, 24'h111222);
  endtask

  task automatic t_tied;
    load_strobe_n = 1'b0;
    put(`CMD_WR_INPUT, `ADDR_CH_B, 12'h456);
    check(chan_b, 12'h456);
    load_strobe_n = 1'b1;
  endtask

  // 23 bits only: must vanish, and the next frame must count afresh
  task automatic t_partial;
    i_master.send(frame(`CMD_WR_UPD_ONE, `ADDR_CH_A, 12'hfff), 23);
    tick(4);
    check(chan_a, 12'h111);
    put(`CMD_WR_UPD_ONE, `ADDR_CH_A, 12'h0c3);
    check(chan_a, 12'h0c3);
  endtask

  task automatic t_ref;
    i_master.send({2'h0, `CMD_REF_SETUP, 19'h00001}, 24);
    tick(4);
    check(ref_out_en, 1'b1);
    put(`CMD_REF_SETUP, `ADDR_CH_A, 12'h000);
    check(ref_out_en, 1'b0);
    // an unlisted command and an unlisted address must change nothing
    put(3'h4, `ADDR_CH_ALL, 12'hfff);
    put(`CMD_WR_UPD_ONE, 3'h2, 12'hfff);
    check({chan_a, chan_b}, 24'h0c3456);
    check(ref_out_en, 1'b0);
  endtask

  // clear mid-frame, then fill the fifo while decode is stalled
  task automatic t_clear;
    fork
      i_master.send(frame(`CMD_WR_UPD_ONE, `ADDR_CH_B, 12'hbbb), 24);
      begin
        tick(80);
        async_clear_n = 1'b0;
      end
    join
    tick(4);
    check({chan_a, chan_b}, 24'h000000);
    check(clear_mode, 1'b1);
    load_strobe_n = 1'b0;
    tick(4);
    load_strobe_n = 1'b1;
    for (int i = 0; i < 9; i++) begin
      put(`CMD_WR_UPD_ONE, `ADDR_CH_A, 12'h100 + i[11:0]);
    end
    check(frame_ready, 1'b0);
    check({chan_a, chan_b}, 24'h000000);
    async_clear_n = 1'b1;
    tick(40);
    check(chan_a, 12'h107);
    check(clear_mode, 1'b0);
    check(frame_ready, 1'b1);
  endtask

  task automatic stop_test;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    rst_n = 1'b0;
    load_strobe_n = 1'b1;
    async_clear_n = 1'b1;
    tick(5);
    rst_n = 1'b1;
    check({ref_out_en, clear_mode, frame_ready}, 3'h1);
    check({chan_a, chan_b}, 24'h000000);
    tick(4);
    t_update();
    t_strobe();
    t_tied();
    t_partial();
    t_ref();
    t_clear();
    stop_test();
  end

  // about two and a half times the expected run length
  initial begin
    #300000;
    failures++;
    stop_test();
  end
endmodule
